// ===== logic/msr_status.sv
// Purpose: Status word, automodem word and interrupt request logic.
// Assumes: Datapath events are one-cycle pulses on ref_clk.
// Notes: Ring pin is asynchronous and passes a three-flop filter.
`timescale 1ns/1ns
`include "msr_cfg.svh"

module msr_status #(
  parameter int unsigned SETTLE_CYC = `MSR_SETTLE_CYC
)(
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Host register access.
  input  wire msr_pkg::msr_host_req_t host_req,
  output logic [15:0]                 rd_data,
  output logic                        rd_valid,
  // Datapath inputs.
  input  wire logic [15:0]            rx_data_in,
  input  wire logic                   prog_flag,
  input  wire msr_pkg::msr_rx_ev_t    rx_ev,
  input  wire msr_pkg::msr_am_t       am_in,
  // Pins.
  input  wire logic                   ring_detect_input_low,
  output logic                        interrupt_out_low,
  // Control seen by the datapath.
  output logic [15:0]                 gcr_out,
  output logic [15:0]                 tx_mode_out
);

  localparam int CW = $clog2(SETTLE_CYC + 1);

  logic [15:0]           gcr_r;
  logic [15:0]           tx_mode_r;
  logic [15:0]           rx_mode_r;
  msr_pkg::msr_rx_mode_t act_mode_r;
  msr_pkg::msr_rx_mode_t req_mode;
  logic [CW-1:0]         settle_r;
  logic                  chg_pend_r;
  logic                  rdn_s1_r;
  logic                  rdn_s2_r;
  logic                  rdn_s3_r;
  logic                  pin_lvl_r;
  logic                  ring_fall;
  logic                  rd_status;
  logic                  rd_rxdata;
  logic                  rd_am;
  logic                  wr_gcr;
  logic                  gen_rst;
  logic                  rx_rdy_r;
  logic                  rx_ovf_r;
  logic                  ferr_r;
  logic                  brk_r;
  logic                  am_evt_r;
  logic                  fsk_r;
  logic                  dtmf_r;
  logic [3:0]            dtmf_code_r;
  logic [5:0]            am_msg_r;
  logic [2:0]            am_snr_r;
  logic [3:0]            am_mode_r;
  logic                  irq_r;
  logic [14:5]           st_hi;
  logic [14:5]           st_prev_r;
  logic [14:5]           mask_vec;
  logic [15:0]           status;
  logic [15:0]           am_word;
  logic                  am_set;
  logic                  irq_set;
  logic                  irq_clr;
  logic                  is_rx;

  // Host strobe decode.
  assign rd_status = host_req.rd && host_req.addr == `MSR_ADDR_STATUS;
  assign rd_rxdata = host_req.rd && host_req.addr == `MSR_ADDR_RXDATA;
  assign rd_am     = host_req.rd && host_req.addr == `MSR_ADDR_AUTOMODE;
  assign wr_gcr    = host_req.wr && host_req.addr == `MSR_ADDR_GCR;
  assign gen_rst   = gcr_r[`MSR_GC_RESET] || gcr_r[`MSR_GC_RESET2];
  assign is_rx     = act_mode_r != msr_pkg::MSR_RX_OFF
                  && act_mode_r != msr_pkg::MSR_RX_DTMF;

  // Control registers written by the host.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gcr_r     <= `MSR_GCR_RST;
      tx_mode_r <= `MSR_MODE_RST;
      rx_mode_r <= `MSR_MODE_RST;
    end
    else if (host_req.wr)
    begin
      if (wr_gcr)
        gcr_r <= host_req.wdata;
      if (host_req.addr == `MSR_ADDR_TXMODE)
        tx_mode_r <= host_req.wdata;
      if (host_req.addr == `MSR_ADDR_RXMODE)
        rx_mode_r <= host_req.wdata;
    end
  end

  // Map the receive mode field onto the status interpretation.
  always_comb
  begin
    case (rx_mode_r[2:0])
      3'h1:    req_mode = msr_pkg::MSR_RX_FSK;
      3'h2:    req_mode = msr_pkg::MSR_RX_QAM;
      3'h3:    req_mode = msr_pkg::MSR_RX_DTMF;
      3'h4:    req_mode = msr_pkg::MSR_RX_MAN;
      default: req_mode = msr_pkg::MSR_RX_OFF;
    endcase
  end

  // A mode write takes effect on the status bits after the settle time,
  // which keeps half-switched datapath events out of the new mode.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      act_mode_r <= msr_pkg::MSR_RX_OFF;
      settle_r   <= '0;
      chg_pend_r <= 1'b0;
    end
    else if (host_req.wr && (host_req.addr == `MSR_ADDR_RXMODE
             || host_req.addr == `MSR_ADDR_TXMODE))
    begin
      settle_r   <= CW'(SETTLE_CYC - 1);
      chg_pend_r <= 1'b1;
    end
    else if (chg_pend_r)
    begin
      if (settle_r == '0)
      begin
        act_mode_r <= req_mode;
        chg_pend_r <= 1'b0;
      end
      else
        settle_r <= settle_r - CW'(1);
    end
  end

  // Ring pin filter; the level changes only when stages two and three agree.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdn_s1_r  <= 1'b1;
      rdn_s2_r  <= 1'b1;
      rdn_s3_r  <= 1'b1;
      pin_lvl_r <= 1'b1;
    end
    else
    begin
      rdn_s1_r <= ring_detect_input_low;
      rdn_s2_r <= rdn_s1_r;
      rdn_s3_r <= rdn_s2_r;
      if (rdn_s2_r == rdn_s3_r)
        pin_lvl_r <= rdn_s3_r;
    end
  end

  // Falling pin edge; not gated by the reset bit so ringing still wakes.
  assign ring_fall = rdn_s2_r == rdn_s3_r && !rdn_s3_r && pin_lvl_r;

  // Data ready and overflow; the set wins over a clearing data read.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_rdy_r <= 1'b0;
      rx_ovf_r <= 1'b0;
    end
    else if (gen_rst)
    begin
      rx_rdy_r <= 1'b0;
      rx_ovf_r <= 1'b0;
    end
    else
    begin
      if (is_rx && rx_ev.rx_ready)
        rx_rdy_r <= 1'b1;
      else if (rd_rxdata || !is_rx)
        rx_rdy_r <= 1'b0;
      if (is_rx && rx_ev.rx_ovf)
        rx_ovf_r <= 1'b1;
      else if (rd_rxdata || !is_rx)
        rx_ovf_r <= 1'b0;
    end
  end

  // Sticky receive error flags, cleared by a status read.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ferr_r <= 1'b0;
      brk_r  <= 1'b0;
    end
    else if (gen_rst)
    begin
      ferr_r <= 1'b0;
      brk_r  <= 1'b0;
    end
    else
    begin
      if (is_rx && rx_ev.frame_err)
        ferr_r <= 1'b1;
      else if (rd_status)
        ferr_r <= 1'b0;
      if (act_mode_r == msr_pkg::MSR_RX_QAM && rx_ev.brk)
        brk_r <= 1'b1;
      else if (rd_status)
        brk_r <= 1'b0;
    end
  end

  // FSK demodulator bit, sampled on the datapath's eight-times-rate tick.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      fsk_r <= 1'b0;
    else if (act_mode_r != msr_pkg::MSR_RX_FSK)
      fsk_r <= 1'b0;
    else if (rx_ev.fsk_stb)
      fsk_r <= rx_ev.fsk_bit;
  end

  // DTMF detection flag and digit code; the code holds until the next digit.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dtmf_r      <= 1'b0;
      dtmf_code_r <= 4'h0;
    end
    else if (gen_rst || act_mode_r != msr_pkg::MSR_RX_DTMF)
    begin
      dtmf_r      <= 1'b0;
      dtmf_code_r <= 4'h0;
    end
    else if (rx_ev.dtmf_det)
    begin
      dtmf_r      <= 1'b1;
      dtmf_code_r <= rx_ev.dtmf_code;
    end
    else if (rd_status)
      dtmf_r <= 1'b0;
  end

  // Automodem fields follow the QAM engine report.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      am_msg_r  <= 6'h00;
      am_snr_r  <= 3'h0;
      am_mode_r <= 4'h0;
    end
    else
    begin
      if (am_in.msg_stb)
        am_msg_r <= am_in.msg;
      am_snr_r  <= am_in.snr;
      am_mode_r <= am_in.mode;
    end
  end

  // Message update, SNR change or mode change raises the event bit.
  assign am_set = act_mode_r == msr_pkg::MSR_RX_QAM
               && (am_in.msg_stb || am_in.snr != am_snr_r
                   || am_in.mode != am_mode_r);

  // Automodem event bit; a word read clears it unless a new event lands.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      am_evt_r <= 1'b0;
    else if (am_set)
      am_evt_r <= 1'b1;
    else if (rd_am || gen_rst)
      am_evt_r <= 1'b0;
  end

  // Assemble the automodem word; bits 9 to 7 are hard zero.
  assign am_word = {am_msg_r, 3'h0, am_snr_r, am_mode_r};

  // Bits 14 to 5 per mode, with their interrupt mask bits.
  always_comb
  begin
    st_hi    = '0;
    mask_vec = '0;
    st_hi[`MSR_ST_PROG] = prog_flag;
    case (act_mode_r)
      msr_pkg::MSR_RX_QAM:
      begin
        st_hi[`MSR_ST_AMEVT] = am_evt_r;
        st_hi[`MSR_ST_BREAK] = brk_r;
        st_hi[`MSR_ST_RXRDY] = rx_rdy_r;
        st_hi[`MSR_ST_RXOVF] = rx_ovf_r;
      end
      msr_pkg::MSR_RX_FSK, msr_pkg::MSR_RX_MAN:
      begin
        st_hi[`MSR_ST_ENERGY] = rx_ev.energy;
        st_hi[9:7]            = rx_ev.pattern;
        st_hi[`MSR_ST_RXRDY]  = rx_rdy_r;
        st_hi[`MSR_ST_RXOVF]  = rx_ovf_r;
      end
      msr_pkg::MSR_RX_DTMF:
        st_hi[`MSR_ST_RXOVF] = dtmf_r;
      default:
        st_hi[`MSR_ST_RXOVF] = 1'b0;
    endcase
    mask_vec[`MSR_ST_ENERGY] = gcr_r[`MSR_GC_MASK_NRG];
    mask_vec[9:7] = {3{gcr_r[`MSR_GC_MASK_PAT]}};
    mask_vec[6:5] = {2{gcr_r[`MSR_GC_MASK_DATA]}};
  end

  // Previous bits for edge detection; ring excluded, it has its own edge.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      st_prev_r <= '0;
    else
      st_prev_r <= st_hi;
  end

  // Interrupt request sources and clears.
  assign irq_set = |(st_hi & ~st_prev_r & mask_vec)
                || (ring_fall && gcr_r[`MSR_GC_RING_A]
                    && gcr_r[`MSR_GC_PIN_EN]);
  assign irq_clr = rd_status || gen_rst
                || (wr_gcr && (host_req.wdata[`MSR_GC_RESET]
                    || host_req.wdata[`MSR_GC_RESET2]));

  // Interrupt request bit; a new event beats a same-cycle clear.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_r <= 1'b0;
    else if (irq_set)
      irq_r <= 1'b1;
    else if (irq_clr)
      irq_r <= 1'b0;
  end

  // Full status word; ring reads the inverted pin in every state.
  always_comb
  begin
    status                = 16'h0000;
    status[`MSR_ST_IRQ]   = irq_r;
    status[`MSR_ST_RING]  = !pin_lvl_r;
    status[13:5]          = st_hi[13:5];
    status[`MSR_ST_FERR]  = is_rx && ferr_r;
    if (act_mode_r == msr_pkg::MSR_RX_DTMF)
      status[3:0] = dtmf_code_r;
    else
      status[`MSR_ST_FSK] = fsk_r;
  end

  // Pin is low while request and enable are both set; one cycle of lag.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      interrupt_out_low <= 1'b1;
    else
      interrupt_out_low <= !(irq_r && gcr_r[`MSR_GC_PIN_EN]);
  end

  // Registered read port; unmapped addresses read zero.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= host_req.rd;
      if (host_req.rd)
      begin
        case (host_req.addr)
          `MSR_ADDR_STATUS:   rd_data <= status;
          `MSR_ADDR_AUTOMODE: rd_data <= am_word;
          `MSR_ADDR_RXDATA:   rd_data <= rx_data_in;
          `MSR_ADDR_GCR:      rd_data <= gcr_r;
          default:            rd_data <= 16'h0000;
        endcase
      end
    end
  end

  // Control copies for the datapath.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gcr_out     <= `MSR_GCR_RST;
      tx_mode_out <= `MSR_MODE_RST;
    end
    else
    begin
      gcr_out     <= gcr_r;
      tx_mode_out <= tx_mode_r;
    end
  end

endmodule

// ===== logic/msr_cfg.svh
// Purpose: Constants for the modem status and interrupt reporting block.
// Assumes: One 125 MHz clock, host access by read and write strobes.
// Notes: Offsets, bit positions, reset values and timing counts.
// Notes on behaviour
// - Interrupt bit rises only for masked-in events; status read clears it.
// - Interrupt pin goes low while interrupt bit and pin enable are set.
// - Receive modes: bit 6 data ready, bit 5 overflow; data read clears.
// - Status may lag a mode change by up to 150 us.
// - Ring bit 14 works in standby and while control reset bit is set.
// - Ring bit is the inverse of the ring input pin level.
// - Ring interrupt only on pin falling edge with control bits 5 and 6.
// - FSK receive: bit 0 shows demodulator output at eight times rate.
// - DTMF receive: detection interrupts only with mask bit 0 set.
// - DTMF digit is a 4-bit tone-pair code in status bits 3 to 0.
// - Automodem status is a 16-bit read-only word at address EB.
// - Automodem word bits 9 to 7 always read zero.
// - Rate sequence codes in bits 15 to 13, rate in bits 12 to 10.
// - Message event codes fill bits 15 to 10; other codes unused.
// - Three-bit rate field encodes 14400 down to 1200 bps.
// - SNR grade sits in bits 6 to 4; code 001 unused.
// - Status bit 9 sets on message update or SNR or mode change.
// - Reading the automodem word clears status bit 9.
// - Interrupt sets on rising status bit 14 to 5 with mask set.
// - Operating mode sits in automodem word bits 3 to 0.
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH

// Register addresses.
`define MSR_ADDR_GCR      8'hE0
`define MSR_ADDR_TXMODE   8'hE1
`define MSR_ADDR_RXMODE   8'hE2
`define MSR_ADDR_RXDATA   8'hE5
`define MSR_ADDR_STATUS   8'hE6
`define MSR_ADDR_AUTOMODE 8'hEB

// Status register bit positions.
`define MSR_ST_IRQ    15
`define MSR_ST_RING   14
`define MSR_ST_PROG   13
`define MSR_ST_ENERGY 10
`define MSR_ST_AMEVT  9
`define MSR_ST_BREAK  8
`define MSR_ST_RXRDY  6
`define MSR_ST_RXOVF  5
`define MSR_ST_FERR   4
`define MSR_ST_FSK    0

// General control register bit positions.
`define MSR_GC_MASK_DATA 0
`define MSR_GC_MASK_PAT  1
`define MSR_GC_MASK_NRG  2
`define MSR_GC_RING_A    5
`define MSR_GC_PIN_EN    6
`define MSR_GC_RESET     7
`define MSR_GC_RESET2    8

// Reset values.
`define MSR_GCR_RST    16'h0000
`define MSR_MODE_RST   16'h0000

// Mode settle time and clock period in ns.
`define MSR_SETTLE_NS  150000
`define MSR_CLK_NS     8
`define MSR_SETTLE_CYC ((`MSR_SETTLE_NS + `MSR_CLK_NS - 1) / `MSR_CLK_NS)

`endif

// ===== logic/msr_pkg.sv
// Purpose: Types for the modem status and interrupt reporting block.
// Assumes: Constants come from msr_cfg.svh.
// Notes: Carriers for host requests and datapath events.
package msr_pkg;

  // Receive operating modes as seen by the status logic.
  typedef enum logic [2:0] {
    MSR_RX_OFF,
    MSR_RX_FSK,
    MSR_RX_QAM,
    MSR_RX_DTMF,
    MSR_RX_MAN
  } msr_rx_mode_t;

  // Host register request, one cycle per strobe.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } msr_host_req_t;

  // Receive datapath events and levels.
  typedef struct packed {
    logic       rx_ready;
    logic       rx_ovf;
    logic       frame_err;
    logic       brk;
    logic       energy;
    logic [2:0] pattern;
    logic       dtmf_det;
    logic [3:0] dtmf_code;
    logic       fsk_bit;
    logic       fsk_stb;
  } msr_rx_ev_t;

  // Automodem report from the QAM engine.
  typedef struct packed {
    logic       msg_stb;
    logic [5:0] msg;
    logic [2:0] snr;
    logic [3:0] mode;
  } msr_am_t;

endpackage

// ===== verif/msr_host_model.sv
// Purpose: Host model that issues register reads and writes to the block.
// Assumes: Requests change just after a rising edge and hold until taken.
// Notes: The answer to a read is awaited for a bounded number of cycles.
`timescale 1ns/1ns
`include "msr_cfg.svh"
module msr_host_model (
  // Clock and device answer.
  input  wire logic              ref_clk,
  input  wire logic              prog_flag,
  input  wire logic [15:0]       rd_data,
  input  wire logic              rd_valid,
  // Request toward the device.
  output msr_pkg::msr_host_req_t host_req
);
  // The bus idles from time zero so no unknown strobe reaches the device.
  initial host_req = '0;

  // One write strobe, dropped at the edge that takes it.
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    host_req.wr <= 1'b0;
  endtask

  // One read strobe; the word is taken at the edge that shows the answer.
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    int n;
    n = 0;
    // The automodem word is only valid while the flag is up.
    while (a == `MSR_ADDR_AUTOMODE && prog_flag !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    host_req.rd <= 1'b0;
    for (n = 0; n < 8 && rd_valid !== 1'b1; n++)
      @(posedge ref_clk);
    d = rd_data;
  endtask
endmodule

// ===== verif/msr_status_props.sv
// Purpose: Concurrent checks on the ports of the status block.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes: Read clearing checks assume no ring edge is still in the filter.
`timescale 1ns/1ns
`include "msr_cfg.svh"
module msr_status_props #(
  parameter int unsigned SETTLE_CYC = 4
)(
  // Clock and reset.
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // Host register access.
  input wire msr_pkg::msr_host_req_t host_req,
  input wire logic [15:0]            rd_data,
  input wire logic                   rd_valid,
  // Datapath inputs.
  input wire logic [15:0]            rx_data_in,
  input wire logic                   prog_flag,
  input wire msr_pkg::msr_rx_ev_t    rx_ev,
  input wire msr_pkg::msr_am_t       am_in,
  // Pins and control copies.
  input wire logic                   ring_detect_input_low,
  input wire logic                   interrupt_out_low,
  input wire logic [15:0]            gcr_out,
  input wire logic [15:0]            tx_mode_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Decoded strobes and any event that could raise the request bit.
  wire logic rd_st  = host_req.rd && host_req.addr == `MSR_ADDR_STATUS;
  wire logic rd_am  = host_req.rd && host_req.addr == `MSR_ADDR_AUTOMODE;
  wire logic wr_rst = host_req.wr && host_req.addr == `MSR_ADDR_GCR &&
                      host_req.wdata[7];
  wire logic ev_any = rx_ev.rx_ready | rx_ev.rx_ovf | rx_ev.frame_err |
                      rx_ev.brk | rx_ev.dtmf_det | am_in.msg_stb;

  // No pulse now, no datapath or ring change since the cycle before, and no
  // report change in the two cycles before, since any of them can still raise the request this cycle.
  sequence s_quiet;
    !ev_any && $stable(rx_ev) && $stable(am_in) &&
    $past(am_in, 2) == am_in && $stable(ring_detect_input_low);
  endsequence
  // The ring pin has stood long enough to pass the filter.
  sequence s_ring_settled;
    $stable(ring_detect_input_low) [*6];
  endsequence

  rd_valid_a: assert property (
    1'b1 |=> rd_valid == $past(host_req.rd))
    else $error("read answer strobe out of step");
  rd_hold_a: assert property (!host_req.rd |=> $stable(rd_data))
    else $error("read data moved without a read");
  pin_enable_a: assert property (
    $fell(interrupt_out_low) |-> gcr_out[6])
    else $error("interrupt pin fell without pin enable");
  irq_clear_a: assert property (
    s_ring_settled ##0 rd_st ##0 s_quiet |-> ##2 interrupt_out_low)
    else $error("status read did not release interrupt pin");
  am_zero_a: assert property (rd_am |=> rd_data[9:7] == 3'h0)
    else $error("automodem word bits 9 to 7 not zero");
  ring_level_a: assert property (
    s_ring_settled ##0 rd_st |=>
    rd_data[14] == !$past(ring_detect_input_low))
    else $error("ring bit does not follow inverted pin");
  ring_irq_a: assert property (
    $fell(ring_detect_input_low) && gcr_out[5] && gcr_out[6] &&
    !gcr_out[7] && !gcr_out[8] |-> ##[3:8] !interrupt_out_low)
    else $error("ring falling edge gave no interrupt");
  reset_clear_a: assert property (
    s_ring_settled ##0 wr_rst ##0 s_quiet |-> ##2 interrupt_out_low)
    else $error("control reset bit did not release interrupt");
endmodule

bind msr_status msr_status_props #(.SETTLE_CYC(SETTLE_CYC)) i_msr_status_props (
  .ref_clk(ref_clk), .rst(rst), .host_req(host_req), .rd_data(rd_data),
  .rd_valid(rd_valid), .rx_data_in(rx_data_in), .prog_flag(prog_flag),
  .rx_ev(rx_ev), .am_in(am_in), .ring_detect_input_low(ring_detect_input_low),
  .interrupt_out_low(interrupt_out_low), .gcr_out(gcr_out),
  .tx_mode_out(tx_mode_out));

// ===== verif/test_msr_status.sv
// Purpose: Self-checking bench for the status and interrupt block.
// Assumes: Settle count shortened to keep the run brief.
// Notes: Ring changes are kept well away from clearing reads.
`timescale 1ns/1ns
`include "msr_cfg.svh"
module test_msr_status;
  localparam int unsigned SETTLE = 4;
  localparam int          LIMIT  = 6000;
  logic                   ref_clk, rst, rd_valid, prog_flag;
  logic                   ring_detect_input_low, interrupt_out_low;
  logic [15:0]            rd_data, rx_data_in, gcr_out, tx_mode_out, got;
  msr_pkg::msr_host_req_t host_req;
  msr_pkg::msr_rx_ev_t    rx_ev, e;
  msr_pkg::msr_am_t       am_in;
  logic [5:0]             msg;
  logic [2:0]             snr;
  int                     errors, num_checks, cyc, i;

  msr_status #(.SETTLE_CYC(SETTLE)) i_msr_status (.ref_clk(ref_clk),
    .rst(rst), .host_req(host_req), .rd_data(rd_data), .rd_valid(rd_valid),
    .rx_data_in(rx_data_in), .prog_flag(prog_flag), .rx_ev(rx_ev),
    .am_in(am_in), .ring_detect_input_low(ring_detect_input_low),
    .interrupt_out_low(interrupt_out_low), .gcr_out(gcr_out),
    .tx_mode_out(tx_mode_out));
  msr_host_model i_msr_host_model (.ref_clk(ref_clk), .prog_flag(prog_flag),
    .rd_data(rd_data), .rd_valid(rd_valid), .host_req(host_req));

  // Free-running 125 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // A hung bus cycle would stall the run, so cycles are capped.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      errors++;
      end_sim();
    end
  end

  // Compare one value and count it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Print the verdict and stop.
  task automatic end_sim;
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Bus shorthands and a one-cycle event pulse.
  task automatic rd(input logic [7:0] a);
    i_msr_host_model.read_reg(a, got);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_msr_host_model.write_reg(a, d);
  endtask
  task automatic pulse(input msr_pkg::msr_rx_ev_t v);
    @(posedge ref_clk);
    rx_ev <= v;
    @(posedge ref_clk);
    rx_ev <= '0;
  endtask
  // Mode change, then a wait past the settle time.
  task automatic set_mode(input logic [15:0] m);
    wr(`MSR_ADDR_RXMODE, m);
    repeat (SETTLE + 4) @(posedge ref_clk);
  endtask

  // Main sequence of scenarios.
  initial
  begin
    rst = 1'b1;
    prog_flag = 1'b0;
    ring_detect_input_low = 1'b1;
    rx_data_in = 16'h5A3C;
    rx_ev = '0;
    am_in = '0;
    errors = 0;
    num_checks = 0;
    cyc = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    set_mode(16'h0001);
    wr(`MSR_ADDR_GCR, 16'h0041);
    e = '0;
    e.rx_ready = 1'b1;
    e.rx_ovf = 1'b1;
    pulse(e);
    repeat (3) @(posedge ref_clk);
    chk(interrupt_out_low, 1'b0);
    rd(`MSR_ADDR_STATUS);
    chk(got[15], 1'b1);
    chk(got[6:5], 2'h3);
    rd(`MSR_ADDR_RXDATA);
    chk(got, 16'h5A3C);
    rd(`MSR_ADDR_STATUS);
    chk(got[15], 1'b0);
    chk(got[6:5], 2'h0);
    chk(interrupt_out_low, 1'b1);
    // A new event in the cycle of the clearing read must survive.
    e.rx_ovf = 1'b0;
    fork
      rd(`MSR_ADDR_RXDATA);
      pulse(e);
    join
    rd(`MSR_ADDR_STATUS);
    chk(got[6], 1'b1);
    rd(`MSR_ADDR_RXDATA);
    // Mask off with pin enabled, then mask on with pin disabled.
    for (i = 0; i < 2; i++)
    begin
      wr(`MSR_ADDR_GCR, i ? 16'h0001 : 16'h0040);
      pulse(e);
      repeat (3) @(posedge ref_clk);
      chk(interrupt_out_low, 1'b1);
      rd(`MSR_ADDR_STATUS);
      chk(got[15], i[0]);
      rd(`MSR_ADDR_RXDATA);
    end
    // Demodulator output follows each strobed sample.
    for (i = 0; i < 2; i++)
    begin
      e = '0;
      e.fsk_stb = 1'b1;
      e.fsk_bit = !i[0];
      pulse(e);
      rd(`MSR_ADDR_STATUS);
      chk(got[0], !i[0]);
    end
    // Every tone-pair code, then one detection with the mask off.
    set_mode(16'h0003);
    wr(`MSR_ADDR_GCR, 16'h0041);
    for (i = 0; i < 17; i++)
    begin
      if (i == 16)
        wr(`MSR_ADDR_GCR, 16'h0040);
      e = '0;
      e.dtmf_det = 1'b1;
      e.dtmf_code = i[3:0];
      pulse(e);
      rd(`MSR_ADDR_STATUS);
      chk(got[3:0], i[3:0]);
      chk(got[15], i < 16);
    end
    // Ring edges with interrupt enabled, then under the control reset bit.
    wr(`MSR_ADDR_GCR, 16'h0060);
    for (i = 0; i < 4; i++)
    begin
      if (i == 2)
        wr(`MSR_ADDR_GCR, 16'h00C0);
      @(posedge ref_clk) ring_detect_input_low <= i[0];
      repeat (12) @(posedge ref_clk);
      chk(interrupt_out_low, i != 0);
      rd(`MSR_ADDR_STATUS);
      chk(got[14], !i[0]);
      chk(got[15], i == 0);
    end
    wr(`MSR_ADDR_GCR, 16'h0000);
    // Automodem messages, rates, grades and modes, each read and cleared.
    set_mode(16'h0002);
    prog_flag <= 1'b1;
    wr(`MSR_ADDR_GCR, 16'h0042);
    for (i = 0; i < 17; i++)
    begin
      msg = (i < 8) ? {3'h3 + 3'(i % 5), i[2:0]} :
            (i < 16) ? 6'h17 - 6'(i - 8) : 6'h0F;
      snr = (i[2:0] == 3'h1) ? 3'h0 : i[2:0];
      @(posedge ref_clk) am_in <= '{1'b1, msg, snr, {1'b1, i[2:0]}};
      @(posedge ref_clk) am_in.msg_stb <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(`MSR_ADDR_STATUS);
      chk(got[9], 1'b1);
      chk(got[15], 1'b1);
      chk(got[13], 1'b1);
      rd(`MSR_ADDR_AUTOMODE);
      chk(got[15:10], msg);
      chk(got[9:7], 3'h0);
      chk(got[6:4], snr);
      chk(got[3:0], {1'b1, i[2:0]});
      rd(`MSR_ADDR_STATUS);
      chk(got[9], 1'b0);
    end
    @(posedge ref_clk) am_in.snr <= 3'h7;
    repeat (3) @(posedge ref_clk);
    rd(`MSR_ADDR_STATUS);
    chk(got[9], 1'b1);
    // Unmapped address reads as zero; control copies reach the datapath.
    rd(8'hFF);
    chk(got, 16'h0000);
    chk(gcr_out, 16'h0042);
    wr(`MSR_ADDR_TXMODE, 16'h00A5);
    repeat (2) @(posedge ref_clk);
    chk(tx_mode_out, 16'h00A5);
    end_sim();
  end
endmodule
